/* hdl/scd_core.v */
// Operation
// - Start request with idle bus in master use generates a START.
// - Start request on an occupied bus waits for a STOP or the bus free timeout first.
// - Start request after a moved byte, before STOP, gives repeated START.
// - Writing one to the stop request bit as master drives a STOP.
// - Stop request bit clears when a STOP is seen on the bus.
// - Start and stop requested together as master: STOP first, then START.
// - Stop request as slave acts as received STOP, nothing driven.
// - Interrupt flag sets on entry to the hold state or on arbitration loss, never idle.
// - Interrupt flag never clears by hardware; software writes zero.
// - Acknowledge slot drives SDA low if acknowledge select is one and a byte is being received.
// - Bus free timer enable gates the SCL-high timeout.
// - Clock-rate value preloads an up-counter; rollover toggles SCL.
// - SCL low time is 256 minus clock-rate value clocks.
// - SCL high time is about 258 minus value clocks plus rise time.
// - Bus free timeout is ten times (256 minus value plus one) clocks.
// - Data shifts out onto SDA most significant bit first.
// - First received bit lands in the most significant bit.
// - Shifting out also shifts SDA in; register holds last bus byte.
// - Arbitration loss turns master transmitter into slave receiver, data kept.
// - Enable bit attaches interface; clearing detaches and drops bus state.
// - Flag set with SCL low holds SCL low until flag cleared and the receive FIFO has room.
// - SCL-low timeout enable reloads timer on SCL high, counts on low.
`timescale 1ns/1ps
`include "scd_map.vh"
module scd_core #(
    parameter FIFO_DEPTH = 4
) (
    input  wire       core_clk,   // System clock, 125 MHz
    input  wire       arst_n,     // Asynchronous reset, active low
    input  wire [1:0] reg_sel,    // Register select
    input  wire       reg_wr,     // Register write strobe
    input  wire [7:0] reg_wdata,  // Register write data
    output reg  [7:0] reg_rdata,  // Selected register, one cycle later
    input  wire       irq_enable, // Serial interrupt enable from CPU
    output wire       irq_req,    // Interrupt request
    input  wire       scl_i,      // SCL pin level
    output wire       scl_o,      // SCL output value, always low
    output wire       scl_oe,     // SCL pull-low enable
    input  wire       sda_i,      // SDA pin level
    output wire       sda_o,      // SDA output value, always low
    output wire       sda_oe,     // SDA pull-low enable
    output wire       tmo_reload, // Force SCL-low timer reload
    output wire       tmo_count,  // Force SCL-low timer count
    output wire [7:0] rx_data,    // Received byte
    output wire       rx_valid,   // Received byte available
    input  wire       rx_ready    // Received byte taken
);
    localparam S_IDLE  = 8'h01;
    localparam S_START = 8'h02;
    localparam S_LOW   = 8'h04;
    localparam S_HIGH  = 8'h08;
    localparam S_HOLD  = 8'h10;
    localparam S_STOP  = 8'h20;
    localparam S_SLV   = 8'h40;
    localparam S_RSTA  = 8'h80;

    reg  [7:0] st_r;
    reg  [7:0] tmr_r;
    reg  [3:0] bit_r;
    reg  [7:0] data_r;
    reg  [7:0] rate_r;
    reg        en_r, sta_r, sto_r, si_r, aa_r, fte_r, toe_r;
    reg        busy_r, master_r, rxm_r, first_r, moved_r;
    reg        scl_drv_r, sda_drv_r, ev_r, sclr_r, push_r;
    reg        scl_d_r, sda_d_r;
    reg  [8:0] ft_r;
    reg  [3:0] fc_r;
    wire       scl_s, sda_s;
    wire       fifo_ok;
    wire       tick, tx, scl_rise, scl_fall;
    wire       start_det, stop_det, free_to;
    wire       wr_ctrl, wr_data;

    scd_sync #(.W(2)) u_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .d_in     ({scl_i, sda_i}),
        .d_out    ({scl_s, sda_s})
    );

    scd_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .in_valid  (push_r),
        .in_ready  (fifo_ok),
        .in_data   (data_r),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    assign scl_o   = 1'b0;
    assign sda_o   = 1'b0;
    assign scl_oe  = scl_drv_r;
    assign sda_oe  = sda_drv_r;
    assign irq_req = si_r & irq_enable;
    assign tmo_reload = en_r & toe_r & scl_s;
    assign tmo_count  = en_r & toe_r & ~scl_s;

    assign wr_ctrl   = reg_wr & (reg_sel == `SCD_SEL_CTRL);
    assign wr_data   = reg_wr & (reg_sel == `SCD_SEL_DATA);
    assign tick      = (tmr_r == `SCD_TMR_END);
    assign tx        = first_r | ~rxm_r;
    assign scl_rise  = scl_s & ~scl_d_r;
    assign scl_fall  = ~scl_s & scl_d_r;
    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
    assign free_to   = (ft_r == `SCD_FT_END) &
                       (fc_r == `SCD_FREE_TICKS - 4'h1);

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // Software registers; hardware sets beat software clears
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            en_r   <= 1'b0;
            sta_r  <= 1'b0;
            sto_r  <= 1'b0;
            si_r   <= 1'b0;
            aa_r   <= 1'b0;
            fte_r  <= 1'b0;
            toe_r  <= 1'b0;
            rate_r <= `SCD_RATE_RST;
        end else begin
            if (wr_ctrl) begin
                en_r  <= reg_wdata[`SCD_B_EN];
                sta_r <= reg_wdata[`SCD_B_STA];
                aa_r  <= reg_wdata[`SCD_B_AA];
                fte_r <= reg_wdata[`SCD_B_FTE];
                toe_r <= reg_wdata[`SCD_B_TOE];
            end
            if (wr_ctrl & reg_wdata[`SCD_B_STO]) begin
                sto_r <= 1'b1;
            end else if (stop_det | sclr_r) begin
                sto_r <= 1'b0;
            end else if (wr_ctrl) begin
                sto_r <= 1'b0;
            end
            if (ev_r) begin
                si_r <= 1'b1;
            end else if (wr_ctrl & ~reg_wdata[`SCD_B_SI]) begin
                si_r <= 1'b0;
            end
            if (reg_wr & (reg_sel == `SCD_SEL_RATE)) begin
                rate_r <= reg_wdata;
            end
        end
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_sel)
                `SCD_SEL_CTRL: reg_rdata <= {busy_r, en_r, sta_r, sto_r,
                                             si_r, aa_r, fte_r, toe_r};
                `SCD_SEL_RATE: reg_rdata <= rate_r;
                `SCD_SEL_DATA: reg_rdata <= data_r;
                default:       reg_rdata <= 8'h00;
            endcase
        end
    end

    // Bus occupancy and free timeout while SCL stays high
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_r <= 1'b0;
            ft_r   <= 9'h000;
            fc_r   <= 4'h0;
        end else if (!en_r) begin
            busy_r <= 1'b0;
            ft_r   <= 9'h000;
            fc_r   <= 4'h0;
        end else begin
            if (start_det) begin
                busy_r <= 1'b1;
            end else if (stop_det | free_to) begin
                busy_r <= 1'b0;
            end
            if (!(fte_r & busy_r & scl_s)) begin
                ft_r <= {1'b0, rate_r};
                fc_r <= 4'h0;
            end else if (ft_r == `SCD_FT_END) begin
                ft_r <= {1'b0, rate_r};
                fc_r <= free_to ? 4'h0 : fc_r + 4'h1;
            end else begin
                ft_r <= ft_r + 9'h001;
            end
        end
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r      <= S_IDLE;
            tmr_r     <= 8'h00;
            bit_r     <= 4'h0;
            data_r    <= `SCD_DATA_RST;
            master_r  <= 1'b0;
            rxm_r     <= 1'b0;
            first_r   <= 1'b0;
            moved_r   <= 1'b0;
            scl_drv_r <= 1'b0;
            sda_drv_r <= 1'b0;
            ev_r      <= 1'b0;
            sclr_r    <= 1'b0;
            push_r    <= 1'b0;
        end else begin
            ev_r   <= 1'b0;
            sclr_r <= 1'b0;
            push_r <= 1'b0;
            if (wr_data) begin
                data_r <= reg_wdata;
            end
            if (!en_r) begin
                st_r      <= S_IDLE;
                master_r  <= 1'b0;
                scl_drv_r <= 1'b0;
                sda_drv_r <= 1'b0;
                bit_r     <= 4'h0;
            end else begin
                case (st_r)
                S_IDLE: begin
                    scl_drv_r <= 1'b0;
                    sda_drv_r <= 1'b0;
                    if (sta_r & ~busy_r) begin
                        st_r      <= S_START;
                        tmr_r     <= rate_r;
                        sda_drv_r <= 1'b1;
                    end else if (sto_r & ~master_r) begin
                        sclr_r <= 1'b1;
                    end else if (start_det) begin
                        st_r  <= S_SLV;
                        bit_r <= 4'h0;
                    end
                end
                S_START: begin
                    tmr_r <= tmr_r + 8'h01;
                    if (tick) begin
                        scl_drv_r <= 1'b1;
                        master_r  <= 1'b1;
                        first_r   <= 1'b1;
                        moved_r   <= 1'b0;
                        ev_r      <= 1'b1;
                        st_r      <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    scl_drv_r <= 1'b1;
                    // Ack or START level let go a cycle after SCL fell
                    if (ev_r) begin
                        sda_drv_r <= 1'b0;
                    end
                    if (!si_r & fifo_ok & !ev_r) begin
                        tmr_r <= rate_r;
                        if (!master_r) begin
                            scl_drv_r <= 1'b0;
                            st_r      <= S_SLV;
                        end else if (sto_r) begin
                            sda_drv_r <= 1'b1;
                            st_r      <= S_STOP;
                        end else if (sta_r & moved_r) begin
                            sda_drv_r <= 1'b0;
                            st_r      <= S_RSTA;
                        end else begin
                            bit_r     <= 4'h0;
                            sda_drv_r <= tx & ~data_r[7];
                            st_r      <= S_LOW;
                        end
                    end
                end
                S_RSTA: begin
                    if (scl_drv_r) begin
                        tmr_r <= tmr_r + 8'h01;
                        if (tick) begin
                            scl_drv_r <= 1'b0;
                            tmr_r     <= rate_r;
                        end
                    end else if (!scl_s) begin
                        tmr_r <= rate_r;
                    end else if (!tick) begin
                        tmr_r <= tmr_r + 8'h01;
                    end else begin
                        sda_drv_r <= 1'b1;
                        tmr_r     <= rate_r;
                        st_r      <= S_START;
                    end
                end
                S_LOW: begin
                    tmr_r <= tmr_r + 8'h01;
                    // Data moves only once SCL is already low
                    if (bit_r == `SCD_ACK_BIT) begin
                        sda_drv_r <= ~tx & aa_r;
                    end else begin
                        sda_drv_r <= tx & ~data_r[7];
                    end
                    if (tick) begin
                        scl_drv_r <= 1'b0;
                        tmr_r     <= rate_r;
                        st_r      <= S_HIGH;
                    end
                end
                S_HIGH: begin
                    // High count starts once the line is seen high
                    if (!scl_s) begin
                        tmr_r <= rate_r;
                    end else if (!tick) begin
                        tmr_r <= tmr_r + 8'h01;
                    end else begin
                        tmr_r     <= rate_r;
                        scl_drv_r <= 1'b1;
                        if (bit_r != `SCD_ACK_BIT) begin
                            data_r <= {data_r[6:0], sda_s};
                        end
                        if (first_r & (bit_r == `SCD_LAST_BIT)) begin
                            rxm_r <= sda_s;
                        end
                        if ((bit_r != `SCD_ACK_BIT) & tx &
                            ~sda_drv_r & ~sda_s) begin
                            master_r  <= 1'b0;
                            scl_drv_r <= 1'b0;
                            sda_drv_r <= 1'b0;
                            ev_r      <= 1'b1;
                            bit_r     <= bit_r + 4'h1;
                            st_r      <= S_SLV;
                        end else if (bit_r == `SCD_ACK_BIT) begin
                            ev_r      <= 1'b1;
                            moved_r   <= 1'b1;
                            push_r    <= ~tx;
                            first_r   <= 1'b0;
                            st_r      <= S_HOLD;
                        end else begin
                            bit_r <= bit_r + 4'h1;
                            st_r  <= S_LOW;
                        end
                    end
                end
                S_STOP: begin
                    if (scl_drv_r) begin
                        tmr_r <= tmr_r + 8'h01;
                        if (tick) begin
                            scl_drv_r <= 1'b0;
                            tmr_r     <= rate_r;
                        end
                    end else if (!scl_s) begin
                        tmr_r <= rate_r;
                    end else begin
                        tmr_r <= tmr_r + 8'h01;
                        if (tick) begin
                            sda_drv_r <= 1'b0;
                            master_r  <= 1'b0;
                            st_r      <= S_IDLE;
                        end
                    end
                end
                S_SLV: begin
                    if (sto_r) begin
                        sda_drv_r <= 1'b0;
                        sclr_r    <= 1'b1;
                        st_r      <= S_IDLE;
                    end else if (stop_det) begin
                        sda_drv_r <= 1'b0;
                        st_r      <= S_IDLE;
                    end else if (start_det) begin
                        bit_r <= 4'h0;
                    end else if (scl_rise) begin
                        bit_r <= bit_r + 4'h1;
                        if (bit_r < `SCD_ACK_BIT) begin
                            data_r <= {data_r[6:0], sda_s};
                        end
                    end else if (scl_fall) begin
                        if (bit_r == `SCD_ACK_BIT) begin
                            sda_drv_r <= aa_r;
                        end else if (bit_r == `SCD_END_BIT) begin
                            sda_drv_r <= 1'b0;
                            bit_r     <= 4'h0;
                            if (aa_r) begin
                                ev_r      <= 1'b1;
                                push_r    <= 1'b1;
                                scl_drv_r <= 1'b1;
                                st_r      <= S_HOLD;
                            end
                        end
                    end
                end
                default: begin
                    st_r <= S_IDLE;
                end
                endcase
            end
        end
    end
endmodule // scd_core

/* hdl/scd_map.vh */
`ifndef SCD_MAP_VH
`define SCD_MAP_VH

// Register selects on the special function register port
`define SCD_SEL_CTRL  2'h0
`define SCD_SEL_RATE  2'h1
`define SCD_SEL_DATA  2'h2

// Reset values
`define SCD_CTRL_RST  8'h00
`define SCD_RATE_RST  8'h00
`define SCD_DATA_RST  8'h00

// Control register bit positions
`define SCD_B_BUSY    7
`define SCD_B_EN      6
`define SCD_B_STA     5
`define SCD_B_STO     4
`define SCD_B_SI      3
`define SCD_B_AA      2
`define SCD_B_FTE     1
`define SCD_B_TOE     0

// Timing counts
`define SCD_TMR_END   8'hFF
`define SCD_FT_END    9'h100
`define SCD_FREE_TICKS 4'hA
`define SCD_ACK_BIT   4'h8
`define SCD_LAST_BIT  4'h7
`define SCD_END_BIT   4'h9

`endif

/* hdl/scd_sync.v */
`timescale 1ns/1ps
module scd_sync #(
    parameter W = 2
) (
    input  wire         core_clk, // System clock
    input  wire         arst_n,   // Asynchronous reset, active low
    input  wire [W-1:0] d_in,     // Asynchronous levels
    output wire [W-1:0] d_out     // Synchronised levels
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    // Idle bus lines read high
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= {W{1'b1}};
            sync_r <= {W{1'b1}};
        end else begin
            meta_r <= d_in;
            sync_r <= meta_r;
        end
    end

    assign d_out = sync_r;
endmodule // scd_sync

/* hdl/scd_fifo.v */
`timescale 1ns/1ps
module scd_fifo #(
    parameter W = 8,
    parameter D = 4
) (
    input  wire         core_clk,  // System clock
    input  wire         arst_n,    // Asynchronous reset, active low
    input  wire         in_valid,  // Write request
    output wire         in_ready,  // Space available
    input  wire [W-1:0] in_data,   // Write data
    output wire         out_valid, // Data available
    input  wire         out_ready, // Read accept
    output wire [W-1:0] out_data   // Head entry
);
    localparam AW = (D > 1) ? $clog2(D) : 1;

    reg [W-1:0] mem_r [0:D-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0]   cnt_r;
    wire         push;
    wire         pop;

    assign in_ready  = (cnt_r != D[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_r[rp_r];

    always @(posedge core_clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    // Pointers wrap at D, which must be a power of two
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            if (push & ~pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop & ~push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // scd_fifo

/* tb/scd_core_properties.sv */
`timescale 1ns/1ps
module scd_core_properties (
    input wire       core_clk,   // System clock
    input wire       arst_n,     // Reset, active low
    input wire [1:0] reg_sel,    // Register select
    input wire       reg_wr,     // Write strobe
    input wire [7:0] reg_wdata,  // Write data
    input wire [7:0] reg_rdata,  // Read data
    input wire       irq_enable, // Interrupt enable
    input wire       irq_req,    // Interrupt request
    input wire       scl_i,      // Clock line level
    input wire       scl_o,      // Clock output value
    input wire       sda_o,      // Data output value
    input wire       scl_oe,     // Clock pull-low enable
    input wire       tmo_reload, // Timer reload
    input wire       tmo_count,  // Timer count
    input wire [7:0] rx_data,    // Received byte
    input wire       rx_valid,   // Received byte available
    input wire       rx_ready    // Received byte taken
);
    reg [7:0] rate_r;
    reg [8:0] lo_r;
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rate_r <= 8'h00;
            lo_r   <= 9'h000;
        end else begin
            if (reg_wr && reg_sel == 2'h1)
                rate_r <= reg_wdata;
            lo_r <= !scl_oe ? 9'h000 : lo_r + {8'h00, ~&lo_r};
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_od; scl_o == 1'b0 && sda_o == 1'b0; endproperty
    a_od: assert property (p_od) else $error("line driven high");
    property p_tmo_hi; scl_i [*4] |-> !tmo_count; endproperty
    a_tmo_hi: assert property (p_tmo_hi) else $error("count on high");
    property p_tmo_lo; !scl_i [*4] |-> !tmo_reload; endproperty
    a_tmo_lo: assert property (p_tmo_lo) else $error("reload on low");
    property p_irq; !irq_enable |-> !irq_req; endproperty
    a_irq: assert property (p_irq) else $error("request while masked");
    property p_si_hold;
        irq_req && !(reg_wr && reg_sel == 2'h0) |=> irq_req || !irq_enable;
    endproperty
    a_si_hold: assert property (p_si_hold) else $error("flag lost");
    property p_stretch; irq_req && scl_oe && !reg_wr |=> scl_oe; endproperty
    a_stretch: assert property (p_stretch) else $error("clock freed");
    property p_low; $fell(scl_oe) |-> lo_r >= 9'h0FF - rate_r; endproperty
    a_low: assert property (p_low) else $error("clock low too short");
    property p_rate;
        reg_wr && reg_sel == 2'h1 ##1 reg_sel == 2'h1
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_rate: assert property (p_rate) else $error("rate readback");
    property p_fifo; rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
    endproperty
    a_fifo: assert property (p_fifo) else $error("byte lost");
    c_low: cover property ($fell(scl_oe));
    c_irq: cover property (irq_req);
    c_pop: cover property (rx_valid && rx_ready);
endmodule // scd_core_properties

bind scd_core scd_core_properties chk_u (.*);

/* tb/scd_partner.sv */
`timescale 1ns/1ps
module scd_partner (
    input  wire       scl,             // Resolved clock line
    input  wire       sda,             // Resolved data line
    input  wire       stretch,         // Hold clock low 80 ns per bit
    output reg        scl_pull = 1'b0, // Pulls clock line low
    output reg        sda_pull = 1'b0, // Pulls data line low
    output reg  [7:0] rx_byte = 8'h00  // Last byte taken from the line
);
    reg [7:0] tx_r = 8'h96;
    reg       rd_r = 1'b0;
    reg       adr_r = 1'b0;
    integer   bit_n = 99;
    always @(negedge sda) if (scl === 1'b1) begin
        bit_n = -1;
        adr_r = 1'b1;
        rd_r = 1'b0;
    end
    always @(posedge sda) if (scl === 1'b1) bit_n = 99;
    always @(posedge scl) begin
        if (bit_n < 8) rx_byte = {rx_byte[6:0], sda};
        else if (bit_n == 8 && rd_r && !adr_r && sda) bit_n = 99;
    end
    always @(negedge scl) if (bit_n < 9) begin
        bit_n = bit_n + 1;
        if (bit_n == 9) begin
            bit_n = 0;
            if (adr_r) rd_r = rx_byte[0];
            else if (rd_r) tx_r = tx_r + 8'h01;
            adr_r = 1'b0;
        end
        sda_pull = (bit_n == 8) ? (adr_r || !rd_r)
                 : (rd_r && !adr_r && !tx_r[7 - bit_n]);
        if (stretch) begin
            scl_pull = 1'b1;
            #80 scl_pull = 1'b0;
        end
    end
endmodule // scd_partner

/* tb/smbus_control_clock_data_test.sv */
`timescale 1ns/1ps
module smbus_control_clock_data_test;
    reg         core_clk = 1'b0;
    reg         arst_n = 1'b0;
    reg  [1:0]  reg_sel = 2'h0;
    reg         reg_wr = 1'b0;
    reg  [7:0]  reg_wdata = 8'h00;
    reg         irq_enable = 1'b1;
    reg         rx_ready = 1'b0;
    reg         stretch = 1'b0;
    wire [7:0]  reg_rdata, rx_data, rx_byte;
    wire        irq_req, scl_o, sda_o, scl_oe, sda_oe, p_scl, p_sda;
    wire        tmo_reload, tmo_count, rx_valid;
    wire        scl_i = ~(scl_oe | p_scl);
    wire        sda_i = ~(sda_oe | p_sda);
    reg  [17:0] rows [0:5];
    reg  [7:0]  v;
    reg  [7:0]  i;
    integer     n, err_total = 0, tests_run = 0;
    always #4 core_clk = ~core_clk;
    scd_core dut_u (.*);
    scd_partner p_u (.scl(scl_i), .sda(sda_i), .stretch(stretch),
        .scl_pull(p_scl), .sda_pull(p_sda), .rx_byte(rx_byte));
    task chk(input [7:0] got, input [7:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task results;
        begin
            if (err_total == 0 && tests_run > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task wr(input [1:0] s, input [7:0] d);
        begin
            @(posedge core_clk);
            reg_sel <= s;
            reg_wr <= 1'b1;
            reg_wdata <= d;
            @(posedge core_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [1:0] s, output [7:0] d);
        begin
            @(posedge core_clk);
            reg_sel <= s;
            @(posedge core_clk);
            @(negedge core_clk);
            d = reg_rdata;
        end
    endtask
    task wait_irq;
        begin
            n = 0;
            @(negedge core_clk);
            while (irq_req !== 1'b1 && n < 4000) begin
                @(negedge core_clk);
                n = n + 1;
            end
            if (n == 4000) begin
                err_total = err_total + 1;
                results;
            end
        end
    endtask
    task idle_chk;
        begin
            v = 8'h00;
            for (n = 0; n < 300 && v !== 8'h44; n = n + 1) rd(2'h0, v);
            chk(v, 8'h44);
        end
    endtask
    initial begin
        rows[0] = {2'h1, 8'hF0, 8'hF0};
        rows[1] = {2'h3, 8'h5A, 8'h00};
        rows[2] = {2'h0, 8'h88, 8'h00};
        rows[3] = {2'h2, 8'hA5, 8'hA5};
        rows[4] = {2'h0, 8'h47, 8'h47};
        rows[5] = {2'h0, 8'h00, 8'h00};
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        for (i = 0; i < 6; i = i + 1) begin
            wr(rows[i][17:16], rows[i][15:8]);
            rd(rows[i][17:16], v);
            chk(v, rows[i][7:0]);
        end
        wr(2'h0, 8'h64);
        wait_irq;
        rd(2'h0, v);
        chk(v, 8'hEC);
        @(posedge core_clk);
        irq_enable <= 1'b0;
        @(negedge core_clk);
        chk({7'h00, irq_req}, 8'h00);
        @(posedge core_clk);
        irq_enable <= 1'b1;
        wr(2'h2, 8'hA4);
        wr(2'h0, 8'h44);
        wait_irq;
        chk(rx_byte, 8'hA4);
        rd(2'h2, v);
        chk(v, 8'hA4);
        wr(2'h0, 8'h54);
        idle_chk;
        stretch <= 1'b1;
        wr(2'h0, 8'h64);
        wait_irq;
        wr(2'h2, 8'hA5);
        wr(2'h0, 8'h44);
        wait_irq;
        for (i = 0; i < 4; i = i + 1) begin
            wr(2'h0, 8'h44);
            wait_irq;
            rd(2'h2, v);
            chk(v, 8'h96 + i);
        end
        for (i = 0; i < 4; i = i + 1) begin
            @(negedge core_clk);
            chk(rx_data, 8'h96 + i);
            @(posedge core_clk);
            rx_ready <= 1'b1;
            @(posedge core_clk);
            rx_ready <= 1'b0;
        end
        @(negedge core_clk);
        chk({7'h00, rx_valid}, 8'h00);
        wr(2'h0, 8'h40);
        wait_irq;
        rd(2'h2, v);
        chk(v, 8'h9A);
        wr(2'h0, 8'h64);
        wait_irq;
        rd(2'h0, v);
        chk(v, 8'hEC);
        wr(2'h2, 8'h5C);
        wr(2'h0, 8'h44);
        wait_irq;
        chk(rx_byte, 8'h5C);
        wr(2'h0, 8'h74);
        wait_irq;
        rd(2'h0, v);
        chk(v, 8'hEC);
        wr(2'h0, 8'h54);
        idle_chk;
        wr(2'h0, 8'h54);
        idle_chk;
        chk({7'h00, sda_oe}, 8'h00);
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            rd(i[1:0], v);
            chk(v, 8'h00);
        end
        chk({6'h00, scl_i, sda_i}, 8'h03);
        results;
    end
endmodule // smbus_control_clock_data_test
